//--- design/card_pin_defines.vh
`ifndef CARD_PIN_DEFINES_VH
`define CARD_PIN_DEFINES_VH
// ----------------------------------------------------------------------
// interface personalities
// ----------------------------------------------------------------------
`define MODE_MEM      2'h0
`define MODE_IO       2'h1
`define MODE_IDE      2'h2
// ----------------------------------------------------------------------
// target space codes reported on targetSpace
// ----------------------------------------------------------------------
`define SPACE_NONE    3'h0
`define SPACE_ATTRIB  3'h1
`define SPACE_COMMON  3'h2
`define SPACE_IOPORT  3'h3
`define SPACE_TASK    3'h4
`define SPACE_CTRL    3'h5
// ----------------------------------------------------------------------
// attribute space split: config registers at and above this address
// ----------------------------------------------------------------------
`define CFG_BASE      11'h200
// ----------------------------------------------------------------------
// status change enable bit in the config/status word
// ----------------------------------------------------------------------
`define CSR_SIGCHG_BIT 3
`define CSR_RESET     8'h00
// ----------------------------------------------------------------------
// byte lane codes: none, even, odd, word, odd-on-low-lanes
// ----------------------------------------------------------------------
`define LANE_NONE     3'h0
`define LANE_EVEN     3'h1
`define LANE_ODD      3'h2
`define LANE_WORD     3'h3
`define LANE_ODDLOW   3'h4
`endif

//--- design/pin_sync.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// two-stage synchroniser for a bundle of pin levels
// ----------------------------------------------------------------------
module pin_sync #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire         ce,
  input  wire [W-1:0] resetVal,
  input  wire [W-1:0] pinIn,
  output reg  [W-1:0] syncOut
);
  reg [W-1:0] meta_q;

  // first stage feeds only the second
  always @(posedge clk) begin
    if (!rst_b) begin
      meta_q  <= resetVal;
      syncOut <= resetVal;
    end else if (ce) begin
      meta_q  <= pinIn;
      syncOut <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

//--- design/card_ide_host_pin_decode.v
// How it works
// RQ1 - card modes decode eleven address lines and reg select to three spaces
// RQ2 - IDE mode uses three low address bits for eight task registers
// RQ3 - host grounds upper address lines in IDE mode
// RQ4 - memory mode holds battery status one high
// RQ5 - I/O mode pulls status change low on ready or protect change if enabled
// RQ6 - memory mode drives battery status two high
// RQ7 - I/O mode drives speaker line high
// RQ8 - IDE mode pass-diagnostic line is bidirectional handshake
// RQ9 - IDE mode activity/slave-present line is bidirectional handshake
// RQ10 - card enables both select the card and pick byte or word
// RQ11 - second enable hits odd byte; first enable uses A0
// RQ12 - eight-bit hosts reach every byte over low lanes
// RQ13 - IDE chip select zero picks task file group
// RQ14 - IDE chip select one picks alternate status and device control
// RQ15 - grounded cable select makes master, open makes slave
// RQ16 - IDE task registers use low byte, data transfers full word
// RQ17 - I/O mode asserts input acknowledge when answering an I/O read
// RQ18 - read data driven only while the selected read strobe (I/O or memory) is low
// RQ19 - first enable alone gives even or odd by A0; both give word
// RQ20 - no enable or select means data undriven and strobes ignored
`timescale 1ns/1ps
`default_nettype none
`include "card_pin_defines.vh"
module card_ide_host_pin_decode (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ce,
  input  wire [1:0]  mode,
  input  wire [7:0]  cfgStatus,
  input  wire        readyLevel,
  input  wire        protectLevel,
  input  wire        dataPortSel,
  input  wire [15:0] readData,
  input  wire [10:0] addrPin,
  input  wire        regSelPin_b,
  input  wire        cardEn1Pin_b,
  input  wire        cardEn2Pin_b,
  input  wire        ioRdPin_b,
  input  wire        ioWrPin_b,
  input  wire        memRdPin_b,
  input  wire        memWrPin_b,
  input  wire        cableSelPin_b,
  input  wire        diagIn_b,
  input  wire        activeIn_b,
  input  wire        driveBusy,
  input  wire        diagPass,
  output reg  [15:0] dataOut,
  output reg  [1:0]  dataOe,
  output reg         inAckPin_b,
  output reg         bvd1Out,
  output reg         bvd1Oe,
  output reg         bvd2Out,
  output reg         bvd2Oe,
  output reg         isMaster,
  output reg         peerDiagOk,
  output reg         peerActive,
  output reg  [2:0]  targetSpace,
  output reg  [10:0] regAddr,
  output reg  [2:0]  laneSel,
  output reg         rdStrobe,
  output reg         wrStrobe
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  wire [20:0] pinRaw = {addrPin, regSelPin_b, cardEn1Pin_b, cardEn2Pin_b,
                        ioRdPin_b, ioWrPin_b, memRdPin_b, memWrPin_b,
                        cableSelPin_b, diagIn_b, activeIn_b};
  wire [20:0] pinS;

  pin_sync #(.W(21)) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .resetVal ({21{1'b1}}),
    .pinIn    (pinRaw),
    .syncOut  (pinS)
  );

  wire [10:0] addrS   = pinS[20:10];
  wire        regS_b  = pinS[9];
  wire        en1S_b  = pinS[8];
  wire        en2S_b  = pinS[7];
  wire        iordS_b = pinS[6];
  wire        iowrS_b = pinS[5];
  wire        mrdS_b  = pinS[4];
  wire        mwrS_b  = pinS[3];
  wire        cselS_b = pinS[2];
  wire        diagS_b = pinS[1];
  wire        actS_b  = pinS[0];

  wire isIde = (mode == `MODE_IDE);
  wire isIo  = (mode == `MODE_IO);
  wire isMem = (mode == `MODE_MEM);

  // ----------------------------------------------------------------------
  // byte lane choice from enables and A0
  // ----------------------------------------------------------------------
  function [2:0] laneOf;
    input e1b;
    input e2b;
    input a0;
    begin
      case ({e2b, e1b})
        2'b00:   laneOf = `LANE_WORD;
        2'b10:   laneOf = a0 ? `LANE_ODDLOW : `LANE_EVEN;
        2'b01:   laneOf = `LANE_ODD;
        default: laneOf = `LANE_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // decode of space, address, lanes
  // ----------------------------------------------------------------------
  reg [2:0]  space_d;
  reg [10:0] addr_d;
  reg [2:0]  lane_d;
  reg        sel_d;
  reg        rdAct_d;
  reg        wrAct_d;

  // IDE gets its own decode; memory and I/O modes share one, told apart by isIo
  always @* begin
    space_d = `SPACE_NONE;
    addr_d  = 11'h000;
    lane_d  = `LANE_NONE;
    sel_d   = 1'b0;
    rdAct_d = 1'b0;
    wrAct_d = 1'b0;
    if (isIde) begin
      // RQ2 three low bits; upper ignored (RQ3 host grounds them)
      addr_d = {8'h00, addrS[2:0]};
      // RQ13 RQ14 chip select groups
      if (!en1S_b) begin
        space_d = `SPACE_TASK;
        sel_d   = 1'b1;
      end else if (!en2S_b) begin
        space_d = `SPACE_CTRL;
        sel_d   = 1'b1;
      end
      // RQ16 data port full word, task regs low byte
      if (sel_d)
        lane_d = (dataPortSel && space_d == `SPACE_TASK) ?
                 `LANE_WORD : `LANE_EVEN;
      rdAct_d = sel_d && !iordS_b;
      wrAct_d = sel_d && !iowrS_b;
    end else begin
      // RQ10 RQ11 RQ19 enables select card and width
      lane_d = laneOf(en1S_b, en2S_b, addrS[0]);
      sel_d  = (lane_d != `LANE_NONE);
      addr_d = addrS;
      // RQ1 reg select, with the I/O strobes in I/O mode, picks the space
      if (sel_d) begin
        if (isIo && !regS_b && (!iordS_b || !iowrS_b))
          space_d = `SPACE_IOPORT;
        else if (!regS_b)
          space_d = `SPACE_ATTRIB;
        else
          space_d = `SPACE_COMMON;
      end
      if (space_d == `SPACE_IOPORT) begin
        rdAct_d = !iordS_b;
        wrAct_d = !iowrS_b;
      end else begin
        rdAct_d = sel_d && !mrdS_b;
        wrAct_d = sel_d && !mwrS_b;
      end
    end
  end

  // ----------------------------------------------------------------------
  // status change latch for I/O mode
  // ----------------------------------------------------------------------
  reg  rdy_q;
  reg  wp_q;
  reg  chg_q;
  wire chgEvent = (readyLevel != rdy_q) || (protectLevel != wp_q);
  // config write clears; a change in the same cycle wins
  wire csrWrite = wrAct_d && (space_d == `SPACE_ATTRIB) &&
                  (addr_d >= `CFG_BASE);

  always @(posedge clk) begin
    if (!rst_b) begin
      // take live levels so no false change follows reset
      rdy_q <= readyLevel;
      wp_q  <= protectLevel;
      chg_q <= 1'b0;
    end else if (ce) begin
      rdy_q <= readyLevel;
      wp_q  <= protectLevel;
      if (chgEvent)
        chg_q <= 1'b1;
      else if (csrWrite)
        chg_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      dataOut     <= 16'h0000;
      dataOe      <= 2'h0;
      inAckPin_b  <= 1'b1;
      bvd1Out     <= 1'b1;
      bvd1Oe      <= 1'b0;
      bvd2Out     <= 1'b1;
      bvd2Oe      <= 1'b0;
      isMaster    <= 1'b0;
      peerDiagOk  <= 1'b0;
      peerActive  <= 1'b0;
      targetSpace <= `SPACE_NONE;
      regAddr     <= 11'h000;
      laneSel     <= `LANE_NONE;
      rdStrobe    <= 1'b0;
      wrStrobe    <= 1'b0;
    end else if (ce) begin
      targetSpace <= space_d;
      regAddr     <= addr_d;
      laneSel     <= lane_d;
      // RQ20 no select, strobes ignored
      rdStrobe    <= rdAct_d;
      wrStrobe    <= wrAct_d;
      // RQ17 acknowledge I/O reads only
      inAckPin_b  <= !(isIo && space_d == `SPACE_IOPORT && rdAct_d);
      // RQ18 RQ20 drive data only during a selected read
      dataOe <= 2'h0;
      dataOut <= readData;
      if (rdAct_d) begin
        case (lane_d)
          `LANE_WORD:   dataOe <= 2'h3;
          `LANE_EVEN:   dataOe <= 2'h1;
          `LANE_ODD:    dataOe <= 2'h2;
          // RQ12 odd byte steered to low lanes
          `LANE_ODDLOW: begin
            dataOe  <= 2'h1;
            dataOut <= {readData[15:8], readData[15:8]};
          end
          default:      dataOe <= 2'h0;
        endcase
      end
      // RQ15 strap resampled on every enabled clock through the synchroniser
      isMaster <= isIde && !cselS_b;
      // RQ8 RQ9 handshake lines open-drain in IDE mode
      peerDiagOk <= isIde && !diagS_b;
      peerActive <= isIde && !actS_b;
      case (mode)
        // RQ4 RQ6 battery lines held high
        `MODE_MEM: begin
          bvd1Out <= 1'b1;
          bvd1Oe  <= 1'b1;
          bvd2Out <= 1'b1;
          bvd2Oe  <= 1'b1;
        end
        `MODE_IO: begin
          // RQ5 gated status change, low when enabled
          bvd1Out <= !(chg_q && cfgStatus[`CSR_SIGCHG_BIT]);
          bvd1Oe  <= 1'b1;
          // RQ7 speaker held high
          bvd2Out <= 1'b1;
          bvd2Oe  <= 1'b1;
        end
        `MODE_IDE: begin
          bvd1Out <= 1'b0;
          bvd1Oe  <= diagPass;
          bvd2Out <= 1'b0;
          bvd2Oe  <= driveBusy;
        end
        default: begin
          bvd1Out <= 1'b1;
          bvd1Oe  <= 1'b0;
          bvd2Out <= 1'b1;
          bvd2Oe  <= 1'b0;
        end
      endcase
    end
  end
endmodule // card_ide_host_pin_decode
`default_nettype wire

//--- tb/pin_decode_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "card_pin_defines.vh"
module pin_decode_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic [1:0]  mode,
  input wire logic        regSelPin_b,
  input wire logic        cardEn1Pin_b,
  input wire logic        cardEn2Pin_b,
  input wire logic        ioRdPin_b,
  input wire logic        cableSelPin_b,
  input wire logic [1:0]  dataOe,
  input wire logic        inAckPin_b,
  input wire logic        bvd1Out,
  input wire logic        bvd1Oe,
  input wire logic        bvd2Out,
  input wire logic        bvd2Oe,
  input wire logic        isMaster,
  input wire logic [2:0]  targetSpace,
  input wire logic [10:0] regAddr,
  input wire logic        rdStrobe,
  input wire logic        wrStrobe
);
  // ----------------------------------------------------------------
  // pin-level relations; four stable edges cover sync plus output reg
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_BVD1_MEM: assert property ((ce && mode == `MODE_MEM)[*4] |->
    bvd1Out && bvd1Oe) else $error("battery line one not high");
  AST_BVD2_MEM: assert property ((ce && mode == `MODE_MEM)[*4] |->
    bvd2Out && bvd2Oe) else $error("battery line two not high");
  AST_SPKR_IO: assert property ((ce && mode == `MODE_IO)[*4] |->
    bvd2Out && bvd2Oe) else $error("speaker line not high");
  AST_NO_SEL: assert property ((ce && cardEn1Pin_b && cardEn2Pin_b)[*4]
    |-> dataOe == 2'h0 && !rdStrobe && !wrStrobe &&
    targetSpace == `SPACE_NONE) else $error("unselected card responds");
  AST_IN_ACK: assert property ((ce && mode == `MODE_IO &&
    !regSelPin_b && !cardEn1Pin_b && !ioRdPin_b)[*4] |-> !inAckPin_b)
    else $error("no input acknowledge on io read");
  AST_OE_RD: assert property (dataOe != 2'h0 |-> rdStrobe)
    else $error("data driven without read strobe");
  AST_IDE_ADDR: assert property ((ce && mode == `MODE_IDE)[*4] ##0
    targetSpace == `SPACE_TASK |-> regAddr[10:3] == 8'h00)
    else $error("upper address used in ide mode");
  AST_MASTER: assert property ((ce && mode == `MODE_IDE &&
    $stable(cableSelPin_b))[*4] |-> isMaster == !cableSelPin_b)
    else $error("master select wrong");
  AST_CTRL_SEL: assert property ((ce && mode == `MODE_IDE &&
    cardEn1Pin_b && !cardEn2Pin_b && !ioRdPin_b)[*4] |->
    targetSpace == `SPACE_CTRL) else $error("control group not selected");
endmodule // pin_decode_checker
bind card_ide_host_pin_decode pin_decode_checker u_chk (.*);
`default_nettype wire

//--- tb/host_socket_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_socket_model (
  input  wire logic        clk,
  input  wire logic        bvd1Out,
  input  wire logic        bvd1Oe,
  input  wire logic        bvd2Out,
  input  wire logic        bvd2Oe,
  output var  logic [10:0] addrPin,
  output var  logic [6:0]  pinsB,
  output wire logic        diagIn_b,
  output wire logic        activeIn_b
);
  logic peerDiag = 1'b0;
  logic peerBusy = 1'b0;
  // open-drain wires
  // pulled up, low when either drive pulls them
  assign diagIn_b = !(peerDiag || (bvd1Oe && !bvd1Out));
  assign activeIn_b = !(peerBusy || (bvd2Oe && !bvd2Out));
  initial begin
    addrPin = 11'h000;
    pinsB = 7'h7f;
  end
  // pins {reg,en1,en2,iord,iowr,memrd,memwr}, held until released
  task automatic drive(input logic [10:0] a, input logic [6:0] p);
    @(posedge clk);
    addrPin <= a;
    pinsB <= p;
  endtask
  // upper lines grounded
  // release flips low lines so stale values never look valid
  task automatic rel;
    @(posedge clk);
    addrPin <= {8'h00, ~addrPin[2:0]};
    pinsB <= 7'h7f;
  endtask
endmodule // host_socket_model
`default_nettype wire

//--- tb/tb_card_ide_host_pin_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "card_pin_defines.vh"
module tb_card_ide_host_pin_decode;
  logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  logic [1:0]  mode = `MODE_MEM;
  logic [7:0]  cfgStatus = 8'h00;
  logic        readyLevel = 1'b0, protectLevel = 1'b0, dataPortSel = 1'b0;
  logic [15:0] readData = 16'ha55a;
  logic        cableSelPin_b = 1'b1, driveBusy = 1'b0, diagPass = 1'b0;
  logic [10:0] addrPin, regAddr;
  logic [6:0]  pinsB;
  logic        diagIn_b, activeIn_b, inAckPin_b, isMaster, peerDiagOk;
  logic        bvd1Out, bvd1Oe, bvd2Out, bvd2Oe, peerActive;
  logic        rdStrobe, wrStrobe;
  logic [15:0] dataOut;
  logic [1:0]  dataOe;
  logic [2:0]  targetSpace, laneSel;
  int          failures = 0, n_checks = 0, cyc = 0;
  wire logic   regSelPin_b = pinsB[6], cardEn1Pin_b = pinsB[5];
  wire logic   cardEn2Pin_b = pinsB[4], ioRdPin_b = pinsB[3];
  wire logic   ioWrPin_b = pinsB[2], memRdPin_b = pinsB[1];
  wire logic   memWrPin_b = pinsB[0];
  card_ide_host_pin_decode u_dut (.*);
  host_socket_model u_host (.*);
  always #5 clk = ~clk;
  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // three edges of latency plus one of margin
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_mem;
    logic [1:0]  en [4] = '{2'b01, 2'b01, 2'b10, 2'b00};
    logic [2:0]  ln [4] = '{`LANE_EVEN, `LANE_ODDLOW, `LANE_ODD, `LANE_WORD};
    logic [1:0]  oe [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
    logic [15:0] dv [4] = '{16'h005a, 16'h00a5, 16'ha500, 16'ha55a};
    settle;
    chk({bvd1Oe, bvd1Out, bvd2Oe, bvd2Out}, 4'hf);
    u_host.drive(11'h200, 7'b0011101);
    settle;
    chk({targetSpace, regAddr}, {`SPACE_ATTRIB, 11'h200});
    for (int i = 0; i < 4; i++) begin
      u_host.drive({10'h008, i[0]}, {1'b1, en[i], 4'b1101});
      settle;
      chk({targetSpace, laneSel, dataOe},
          {`SPACE_COMMON, ln[i], oe[i]});
      chk(dataOut & {{8{oe[i][1]}}, {8{oe[i][0]}}}, dv[i]);
    end
    u_host.rel;
    $display("memory mode test done");
  endtask
  task automatic t_io;
    @(posedge clk) mode <= `MODE_IO;
    u_host.drive(11'h1f0, 7'b0010111);
    settle;
    chk({bvd2Oe, bvd2Out}, 2'b11);
    chk({targetSpace, inAckPin_b, rdStrobe, dataOe},
        {`SPACE_IOPORT, 1'b0, 1'b1, 2'h1});
    u_host.drive(11'h1f0, 7'b0011111);
    settle;
    chk({inAckPin_b, dataOe}, 3'b100);
    u_host.drive(11'h1f0, 7'b0011011);
    settle;
    chk({targetSpace, inAckPin_b, wrStrobe, dataOe},
        {`SPACE_IOPORT, 1'b1, 1'b1, 2'h0});
    u_host.drive(11'h1f0, 7'b0110111);
    settle;
    chk({targetSpace, inAckPin_b, rdStrobe, dataOe}, 8'h08);
    @(posedge clk) cfgStatus <= 8'h08;
    @(posedge clk) readyLevel <= 1'b1;
    settle;
    chk({bvd1Oe, bvd1Out}, 2'b10);
    u_host.drive(11'h200, 7'b0011110);
    settle;
    chk(bvd1Out, 1'b1);
    u_host.rel;
    @(posedge clk) cfgStatus <= 8'h00;
    @(posedge clk) protectLevel <= 1'b1;
    settle;
    chk(bvd1Out, 1'b1);
    @(posedge clk) cfgStatus <= 8'h08;
    settle;
    chk(bvd1Out, 1'b0);
    $display("io mode test done");
  endtask
  task automatic t_ide;
    @(posedge clk) mode <= `MODE_IDE;
    cableSelPin_b <= 1'b0;
    settle;
    chk(isMaster, 1'b1);
    @(posedge clk) cableSelPin_b <= 1'b1;
    u_host.drive(11'h007, 7'b1010111);
    settle;
    chk(isMaster, 1'b0);
    chk({targetSpace, regAddr, dataOe},
        {`SPACE_TASK, 11'h007, 2'h1});
    @(posedge clk) dataPortSel <= 1'b1;
    settle;
    chk(dataOe, 2'h3);
    u_host.drive(11'h006, 7'b1100111);
    settle;
    chk(targetSpace, `SPACE_CTRL);
    @(posedge clk) u_host.peerDiag <= 1'b1;
    settle;
    chk({peerDiagOk, peerActive, bvd1Oe, bvd2Oe}, 4'h8);
    @(posedge clk) u_host.peerBusy <= 1'b1;
    driveBusy <= 1'b1;
    diagPass <= 1'b1;
    settle;
    chk({peerDiagOk, peerActive, bvd1Oe, bvd1Out, bvd2Oe, bvd2Out},
        6'h3a);
    u_host.rel;
    $display("ide mode test done");
  endtask
  // clock enable low must freeze the whole pipeline
  task automatic t_hold;
    settle;
    @(posedge clk) ce <= 1'b0;
    u_host.drive(11'h005, 7'b1010111);
    settle;
    chk({targetSpace, regAddr, dataOe},
        {`SPACE_NONE, 11'h001, 2'h0});
    @(posedge clk) ce <= 1'b1;
    settle;
    chk({targetSpace, regAddr, dataOe},
        {`SPACE_TASK, 11'h005, 2'h3});
    u_host.rel;
    $display("clock enable test done");
  endtask
  // ------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_mem;
    t_io;
    t_ide;
    t_hold;
    complete_run;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      complete_run;
    end
  end
endmodule // tb_card_ide_host_pin_decode
`default_nettype wire
